// file: shc_standby_hold_controller.sv
// standby hold controller: command port, hold, warm-up and restart
// What this block does
// - backup mode: hold while pin low, run high
// - clock mode: hold until pin rising edge
// - command port write starts standby, sets mode/warm-up
// - status port shows standby pin level
// - standby stops oscillator and internal operation
// - entering standby clears divider to zero
// - memory, registers, port latches kept during standby
// - program counter keeps next instruction address
// - backup mode: pin high releases standby
// - backup mode: pin already high skips to restart
// - restart: oscillator on, halt for warm-up
// - resume after warm-up, divider from zero
// - warm-up counted in basic clocks by divider
// - reset in standby initializes at once, no warm-up
// - reset clears divider, program counter to zero
`timescale 1ns/1ps

module shc_standby_hold_controller
  import shc_pkg::*;
(
  // clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rstn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // standby request pin
  input  wire logic              standbyPin,
  // core side
  input  wire logic [PC_W-1:0]   nextPc,
  output logic                   oscEnable,
  output logic                   coreHalt,
  output logic                   pcRestore,
  output logic [PC_W-1:0]        resumePc,
  output logic [DIV_W-1:0]       divider
);

  // ==========================================================
  // apb decode
  logic                 access;
  logic                 wrCmd;
  logic                 mapped;
  logic                 startReq;
  logic                 pinRise;
  logic [DIV_W-1:0]     warmLen;
  shc_state_t           state_q;
  shc_state_t           state_d;
  shc_mode_t            mode_q;
  logic [CMD_WARM_W-1:0] warmSel_q;
  logic                 pin_q;
  logic [DIV_W-1:0]     div_q;
  logic [PC_W-1:0]      pc_q;
  logic                 pready_q;
  logic [31:0]          prdata_q;
  logic                 pslverr_q;
  logic                 oscEn_q;
  logic                 halt_q;
  logic                 restore_q;

  // one wait state keeps pready straight from a flop
  assign access = psel && penable && !pready_q;
  assign mapped = (paddr == ADDR_CMD) || (paddr == ADDR_STATUS)
               || (paddr == ADDR_DIVIDER) || (paddr == ADDR_RESUME);
  assign wrCmd  = access && pwrite && (paddr == ADDR_CMD);
  assign startReq = wrCmd && pwdata[CMD_START_BIT] && (state_q == SHC_RUN);

  // ==========================================================
  // standby pin sampling; runs on the always-on clock
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pin_q <= 1'b0;
    end else begin
      pin_q <= standbyPin;
    end
  end

  assign pinRise = standbyPin && !pin_q;

  // ==========================================================
  // command port
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      mode_q    <= shc_mode_t'(CMD_MODE_RST);
      warmSel_q <= CMD_WARM_RST;
    end else if (wrCmd && state_q == SHC_RUN) begin
      mode_q    <= shc_mode_t'(pwdata[CMD_MODE_BIT]);
      warmSel_q <= pwdata[CMD_WARM_LSB +: CMD_WARM_W];
    end
  end

  always_comb begin
    unique case (warmSel_q)
      2'h0: warmLen = WARM_CYC_0;
      2'h1: warmLen = WARM_CYC_1;
      2'h2: warmLen = WARM_CYC_2;
      2'h3: warmLen = WARM_CYC_3;
    endcase
  end

  // ==========================================================
  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      SHC_RUN: begin
        if (startReq) begin
          // backup mode with pin already high goes straight to restart
          // mode comes from this very write, not from the previous command
          if (pwdata[CMD_MODE_BIT] == 1'b0 && standbyPin) begin
            state_d = SHC_WARM;
          end else begin
            state_d = SHC_HOLD;
          end
        end
      end
      SHC_HOLD: begin
        if (mode_q == SHC_BACKUP && standbyPin) begin
          state_d = SHC_WARM;
        end else if (mode_q == SHC_CLOCK && pinRise) begin
          state_d = SHC_WARM;
        end
      end
      SHC_WARM: begin
        if (div_q == warmLen - 16'h0001) begin
          state_d = SHC_RUN;
        end
      end
      default: state_d = SHC_RUN;
    endcase
  end

  // async reset drops any standby at once; no warm-up follows
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= SHC_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================
  // divider: the warm-up timer is the divider itself
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      div_q <= DIV_RST;
    end else if (startReq) begin
      div_q <= DIV_RST;
    end else if (state_q == SHC_HOLD) begin
      div_q <= div_q;
    end else if (state_q == SHC_WARM && state_d == SHC_RUN) begin
      div_q <= DIV_RST;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end

  // ==========================================================
  // program counter save and restore
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pc_q <= PC_RST;
    end else if (startReq) begin
      pc_q <= nextPc;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      restore_q <= 1'b0;
    end else begin
      restore_q <= (state_q == SHC_WARM) && (state_d == SHC_RUN);
    end
  end

  // ==========================================================
  // oscillator and core control; halt freezes core state in place
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oscEn_q <= 1'b1;
      halt_q  <= 1'b0;
    end else begin
      oscEn_q <= (state_d != SHC_HOLD);
      halt_q  <= (state_d != SHC_RUN);
    end
  end

  // ==========================================================
  // apb response
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= access;
      pslverr_q <= access && !mapped;
      prdata_q  <= 32'h0000_0000;
      if (access && !pwrite) begin
        unique case (paddr)
          ADDR_CMD: begin
            prdata_q[CMD_WARM_LSB +: CMD_WARM_W] <= warmSel_q;
            prdata_q[CMD_MODE_BIT] <= mode_q;
          end
          ADDR_STATUS: begin
            prdata_q[ST_PIN_BIT]  <= pin_q;
            prdata_q[ST_HOLD_BIT] <= (state_q == SHC_HOLD);
            prdata_q[ST_WARM_BIT] <= (state_q == SHC_WARM);
          end
          ADDR_DIVIDER: prdata_q[DIV_W-1:0] <= div_q;
          ADDR_RESUME:  prdata_q[PC_W-1:0]  <= pc_q;
          default:      prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign prdata    = prdata_q;
  assign oscEnable = oscEn_q;
  assign coreHalt  = halt_q;
  assign pcRestore = restore_q;
  assign resumePc  = pc_q;
  assign divider   = div_q;

endmodule

// file: shc_pkg.sv
// shared constants for the standby hold controller
package shc_pkg;

  // ==========================================================
  // bus and register map
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  ADDR_CMD     = 8'h00;
  localparam logic [7:0]  ADDR_STATUS  = 8'h04;
  localparam logic [7:0]  ADDR_DIVIDER = 8'h08;
  localparam logic [7:0]  ADDR_RESUME  = 8'h0C;

  // ==========================================================
  // command port fields
  localparam int          CMD_WARM_LSB = 0;
  localparam int          CMD_WARM_W   = 2;
  localparam int          CMD_MODE_BIT = 2;
  localparam int          CMD_START_BIT = 3;
  localparam logic [1:0]  CMD_WARM_RST = 2'h0;
  localparam logic        CMD_MODE_RST = 1'b0;

  // ==========================================================
  // status port fields
  localparam int          ST_PIN_BIT   = 0;
  localparam int          ST_HOLD_BIT  = 1;
  localparam int          ST_WARM_BIT  = 2;

  // ==========================================================
  // divider, program counter and warm-up lengths in basic clocks
  localparam int          DIV_W        = 16;
  localparam int          PC_W         = 12;
  localparam logic [15:0] DIV_RST      = 16'h0000;
  localparam logic [11:0] PC_RST       = 12'h000;
  localparam logic [15:0] WARM_CYC_0   = 16'h0040;
  localparam logic [15:0] WARM_CYC_1   = 16'h0100;
  localparam logic [15:0] WARM_CYC_2   = 16'h0400;
  localparam logic [15:0] WARM_CYC_3   = 16'h1000;

  // ==========================================================
  // modes and states
  typedef enum logic {SHC_BACKUP, SHC_CLOCK} shc_mode_t;
  typedef enum logic [1:0] {SHC_RUN, SHC_HOLD, SHC_WARM} shc_state_t;

endpackage

// file: shc_chk.sv
// port checker for the standby hold controller
`timescale 1ns/1ps

module shc_chk
  import shc_pkg::*;
(
  // clock and reset
  input wire logic              sys_clk,
  input wire logic              rstn,
  // apb
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  // standby
  input wire logic              standbyPin,
  input wire logic              oscEnable,
  input wire logic              coreHalt,
  input wire logic              pcRestore,
  input wire logic [DIV_W-1:0]  divider
);
  // ==========================================================
  // properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  wire takeNow = psel && penable && !pready;

  a_apb_answer: assert property (takeNow |=> pready) else $error("access not answered");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held too long");
  a_unmapped_err: assert property (takeNow && paddr > 8'h0C |=> pslverr)
    else $error("unmapped access without error");
  a_stop_halts: assert property (!oscEnable |-> coreHalt) else $error("core runs, osc off");
  a_entry_clear: assert property ($fell(oscEnable) |-> divider == 16'h0000)
    else $error("divider not cleared at entry");
  a_hold_frozen: assert property (!oscEnable && !$past(oscEnable) |-> $stable(divider))
    else $error("divider moved in standby");
  // entry cycle excluded: clock mode needs an edge after entry
  a_edge_wakes: assert property (!oscEnable && !$past(oscEnable) && $rose(standbyPin)
    |=> oscEnable) else $error("pin edge did not wake");
  a_warm_halted: assert property ($rose(oscEnable) && coreHalt |-> coreHalt[*8])
    else $error("warm-up too short");
  a_restore_end: assert property (pcRestore |-> !coreHalt && divider == 16'h0000
    && $past(coreHalt)) else $error("bad resume");

  c_entry: cover property ($fell(oscEnable));
  c_resume: cover property (pcRestore);
  c_unmapped: cover property (takeNow && paddr > 8'h0C);
endmodule

bind shc_standby_hold_controller shc_chk i_chk (
  .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
  .pready(pready), .pslverr(pslverr), .standbyPin(standbyPin), .oscEnable(oscEnable),
  .coreHalt(coreHalt), .pcRestore(pcRestore), .divider(divider)
);

// file: shc_pin_src.sv
// standby request source driving the standby pin
`timescale 1ns/1ps

module shc_pin_src (
  // clock
  input  wire logic sys_clk,
  // pin
  output logic      standbyPin
);
  initial standbyPin = 1'h0;
  // pushed level, never floats: a real source holds the pin
  task automatic drive(input logic v);
    @(posedge sys_clk);
    standbyPin <= v;
  endtask
endmodule

// file: shc_standby_hold_controller_bench.sv
// testbench for the standby hold controller
`timescale 1ns/1ps

module shc_standby_hold_controller_bench
  import shc_pkg::*;
;
  logic              sys_clk = 1'h0;
  logic              rstn = 1'h0;
  logic              psel = 1'h0;
  logic              penable = 1'h0;
  logic              pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = 8'h00;
  logic [31:0]       pwdata = 32'h0;
  logic [PC_W-1:0]   nextPc = 12'h000;
  logic [31:0]       prdata, rd;
  logic [PC_W-1:0]   resumePc;
  logic [DIV_W-1:0]  divider;
  logic              pready, pslverr, err, standbyPin, oscEnable, coreHalt, pcRestore;
  logic [15:0]       lens [4] = '{WARM_CYC_0, WARM_CYC_1, WARM_CYC_2, WARM_CYC_3};
  int                n_errors = 0;
  int                samples_checked = 0;

  always #25 sys_clk = ~sys_clk;

  shc_pin_src i_pin (.sys_clk(sys_clk), .standbyPin(standbyPin));
  shc_standby_hold_controller i_dut (
    .sys_clk(sys_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .standbyPin(standbyPin), .nextPc(nextPc), .oscEnable(oscEnable), .coreHalt(coreHalt),
    .pcRestore(pcRestore), .resumePc(resumePc), .divider(divider)
  );

  // ==========================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask

  // holds the request until ready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'h1;
    do @(posedge sys_clk); while (pready !== 1'h1);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  // counts halted cycles with the oscillator running, up to the resume pulse
  task automatic warm(input int len);
    int n = 0;
    do begin
      @(posedge sys_clk);
      if (coreHalt === 1'h1 && oscEnable === 1'h1) n++;
    end while (pcRestore !== 1'h1 && n < 5000);
    chk(32'(n), 32'(len));
    chk(32'(divider), 32'h0);
  endtask

  task report_and_stop;
    $display("errors=%0d checks=%0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================
  // tests
  initial begin
    cyc(16);
    rstn <= 1'h1;
    apb(1'h0, ADDR_RESUME, 32'h0);
    chk(rd, 32'h0);
    apb(1'h0, 8'h10, 32'h0);
    chk(32'(err), 32'h1);
    for (int v = 0; v < 2; v++) begin
      i_pin.drive(v[0]);
      cyc(3);
      apb(1'h0, ADDR_STATUS, 32'h0);
      chk(32'(rd[ST_PIN_BIT]), 32'(v));
    end
    for (int w = 0; w < 4; w++) begin
      i_pin.drive(1'h0);
      nextPc <= 12'h5A0 + 12'(w);
      apb(1'h1, ADDR_CMD, 32'h8 | 32'(w));
      cyc(20);
      chk(32'({oscEnable, coreHalt, divider}), 32'h10000);
      i_pin.drive(1'h1);
      warm(lens[w]);
      apb(1'h0, ADDR_RESUME, 32'h0);
      chk(rd, 32'h5A0 + 32'(w));
      chk(32'(resumePc), 32'h5A0 + 32'(w));
    end
    apb(1'h1, ADDR_CMD, 32'h9);
    chk(32'({oscEnable, coreHalt}), 32'h3);
    warm(lens[1] - 1);
    apb(1'h1, ADDR_CMD, 32'hE);
    cyc(10);
    chk(32'(oscEnable), 32'h0);
    i_pin.drive(1'h0);
    i_pin.drive(1'h1);
    warm(lens[2]);
    // back to backup mode from clock mode with the pin high: restart at once
    apb(1'h1, ADDR_CMD, 32'h8);
    chk(32'({oscEnable, coreHalt}), 32'h3);
    warm(lens[0] - 1);
    apb(1'h1, ADDR_CMD, 32'hF);
    cyc(5);
    rstn <= 1'h0;
    cyc(2);
    rstn <= 1'h1;
    cyc(2);
    chk(32'({oscEnable, coreHalt}), 32'h2);
    chk(32'(resumePc), 32'h0);
    report_and_stop;
  end

  initial begin
    repeat (30000) @(posedge sys_clk);
    n_errors++;
    report_and_stop;
  end
endmodule
